// ### logic/iec_card.sv
/*
 encoder card logic: pin filtering for encoder and pulse-reference
 channels, quadrature divider with index pass-through, encoder loss
 detection and the three indicators. assumes all pins are asynchronous
 to i_clk and the drive presents its ratio and link state as levels.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iec_params.svh"
module iec_card
   import iec_pkg::*;
#(
   parameter int BLINK_HALF_CYC = `IEC_BLINK_HALF_CYC,
   parameter int LOSS_CYC = `IEC_LOSS_CYC,
   parameter int FILT_LEN = `IEC_FILT_LEN,
   parameter bit HV_VARIANT = 1'b0
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // encoder and pulse-reference pins
   input wire iec_abz_type i_enc,
   input wire iec_abz_type i_ref,
   // drive control board
   input wire logic i_link_setup,
   input wire logic i_link_up,
   input wire logic i_comm_fault,
   input wire logic i_power_fed,
   input wire logic i_motion_expected,
   input wire logic i_ratio_sel,
   input wire logic [7:0] i_division_ratio_param_first,
   input wire logic [7:0] i_division_ratio_param_second,
   // divided and reference outputs and status
   output iec_abz_type o_div,
   output iec_abz_type o_ref,
   output logic o_enc_dir,
   output logic o_enc_loss,
   output iec_ind_type o_ind
);
   localparam int FL = FILT_LEN;

   initial begin
      if (FL < 1 || FL > `IEC_MIN_EDGE_CYC)
         $error("filter length cannot serve 200 kHz inputs");
      if (BLINK_HALF_CYC < 1 || LOSS_CYC < 1)
         $error("timing counts must be positive");
   end

   // two-stage synchronisers on all async pins except the two division ratio parameters
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic [2:0] link_s1_ff;
   logic [2:0] link_s2_ff;
   logic [2:0] flt_s1_ff;
   logic [2:0] flt_s2_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
         link_s1_ff <= 3'h0;
         link_s2_ff <= 3'h0;
         flt_s1_ff <= 3'h0;
         flt_s2_ff <= 3'h0;
      end else begin
         sync1_ff <= {i_enc, i_ref};
         sync2_ff <= sync1_ff;
         link_s1_ff <= {i_link_setup, i_link_up, i_power_fed};
         link_s2_ff <= link_s1_ff;
         flt_s1_ff <= {i_comm_fault, i_motion_expected, i_ratio_sel};
         flt_s2_ff <= flt_s1_ff;
      end
   end

   // glitch filter: a level must hold FL+1 samples; short enough for 200 kHz quadrature
   logic [5:0] filt_ff;
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_filt
         logic [FL-1:0] hist_ff;
         wire all_hi = &{hist_ff, sync2_ff[g]};
         wire all_lo = ~|{hist_ff, sync2_ff[g]};
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               hist_ff <= '0;
               filt_ff[g] <= 1'b0;
            end else begin
               hist_ff <= (FL > 1) ? {hist_ff[FL-2:0], sync2_ff[g]} : sync2_ff[g];
               if (all_hi)
                  filt_ff[g] <= 1'b1;
               else if (all_lo)
                  filt_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // quadrature decode of encoder a/b
   logic [2:0] enc_prev_ff;
   wire enc_a = filt_ff[5];
   wire enc_b = filt_ff[4];
   wire enc_z = filt_ff[3];
   wire a_edge = enc_a ^ enc_prev_ff[2];
   wire b_edge = enc_b ^ enc_prev_ff[1];
   wire any_edge = a_edge | b_edge;
   wire step = any_edge & ~(a_edge & b_edge);
   // forward when a changes to differ from b, or b changes to match a (a-leads sense)
   wire fwd = a_edge ? (enc_a ^ enc_b) : ~(enc_a ^ enc_b);
   wire z_rise = enc_z & ~enc_prev_ff[0];

   // ratio from the selected drive parameter, zero treated as one
   wire [7:0] ratio_raw = flt_s2_ff[0] ? i_division_ratio_param_second
                                       : i_division_ratio_param_first;
   wire [7:0] ratio = (ratio_raw < `IEC_RATIO_MIN) ? `IEC_RATIO_MIN : ratio_raw;

   // divider: one output quadrature step per ratio input steps
   logic [7:0] div_cnt_ff;
   logic [1:0] out_ph_ff;
   logic out_z_ff;
   logic dir_ff;
   wire cnt_wrap = fwd ? (div_cnt_ff + 8'h01 >= ratio) : (div_cnt_ff == 8'h00);
   wire [7:0] nxt_div_cnt = fwd ? (cnt_wrap ? 8'h00 : div_cnt_ff + 8'h01)
                                : (cnt_wrap ? ratio - 8'h01 : div_cnt_ff - 8'h01);
   // gray step sequence keeps a/b a quarter cycle apart in either direction
   wire [1:0] ph_bin_next = fwd ? out_ph_ff + 2'h1 : out_ph_ff - 2'h1;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         enc_prev_ff <= 3'h0;
         div_cnt_ff <= 8'h00;
         out_ph_ff <= 2'h0;
         out_z_ff <= 1'b0;
         dir_ff <= 1'b0;
      end else begin
         enc_prev_ff <= {enc_a, enc_b, enc_z};
         if (step) begin
            div_cnt_ff <= nxt_div_cnt;
            dir_ff <= fwd;
            if (cnt_wrap)
               out_ph_ff <= ph_bin_next;
         end
         out_z_ff <= enc_z;
         if (z_rise && ratio != 8'h01)
            div_cnt_ff <= 8'h00;
      end
   end

   // outputs: phase 0..3 -> (a,b) = 00,10,11,01
   logic [2:0] div_out_ff;
   logic [2:0] ref_out_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_out_ff <= 3'h0;
         ref_out_ff <= 3'h0;
      end else begin
         div_out_ff <= {out_ph_ff[1] ^ out_ph_ff[0], out_ph_ff[1], out_z_ff};
         ref_out_ff <= filt_ff[2:0];
      end
   end

   // encoder loss: no a/b edge for LOSS_CYC while motion is expected
   localparam int LW = $clog2(LOSS_CYC + 1);
   logic [LW-1:0] loss_cnt_ff;
   logic loss_ff;
   wire loss_hit = (loss_cnt_ff == LW'(LOSS_CYC));
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         loss_cnt_ff <= '0;
         loss_ff <= 1'b0;
      end else if (any_edge || !flt_s2_ff[1]) begin
         loss_cnt_ff <= '0;
         if (any_edge)
            loss_ff <= 1'b0;
      end else if (loss_hit) begin
         loss_ff <= 1'b1;
      end else begin
         loss_cnt_ff <= loss_cnt_ff + LW'(1);
      end
   end

   // link state: setup wins over up, neither means lost
   iec_link_type link_st;
   assign link_st = link_s2_ff[2] ? IEC_LK_SETUP :
                    link_s2_ff[1] ? IEC_LK_UP : IEC_LK_OFF;

   // 0.5 s blink base for the link led only
   localparam int BW = $clog2(BLINK_HALF_CYC + 1);
   logic [BW-1:0] blink_cnt_ff;
   logic blink_ff;
   wire blink_wrap = (blink_cnt_ff == BW'(BLINK_HALF_CYC - 1));
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b1;
      end else if (link_st != IEC_LK_UP) begin
         // restart so the first blink phase after link-up is a full 0.5 s lit
         blink_cnt_ff <= '0;
         blink_ff <= 1'b1;
      end else if (blink_wrap) begin
         blink_cnt_ff <= '0;
         blink_ff <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + BW'(1);
      end
   end

   logic nxt_link_led;
   always_comb begin
      case (link_st)
         IEC_LK_SETUP: nxt_link_led = 1'b1;
         IEC_LK_UP: nxt_link_led = blink_ff;
         IEC_LK_OFF: nxt_link_led = 1'b0;
         default: nxt_link_led = 1'b0;
      endcase
   end

   // encoder indicator: loss dark, fault blinks on hv variant, else lit
   logic blink_free_ff;
   wire nxt_enc_led = loss_ff ? 1'b0 :
                      (HV_VARIANT && flt_s2_ff[2]) ? blink_free_ff :
                      1'b1;

   // free-running blink for the fault display, independent of the link
   logic [BW-1:0] free_cnt_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         free_cnt_ff <= '0;
         blink_free_ff <= 1'b1;
      end else if (free_cnt_ff == BW'(BLINK_HALF_CYC - 1)) begin
         free_cnt_ff <= '0;
         blink_free_ff <= ~blink_free_ff;
      end else begin
         free_cnt_ff <= free_cnt_ff + BW'(1);
      end
   end

   iec_ind_type ind_ff;
   logic loss_out_ff;
   logic dir_out_ff;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ind_ff <= '0;
         loss_out_ff <= 1'b0;
         dir_out_ff <= 1'b0;
      end else begin
         ind_ff.link <= nxt_link_led;
         ind_ff.enc <= nxt_enc_led;
         ind_ff.pwr <= link_s2_ff[0];
         loss_out_ff <= loss_ff;
         dir_out_ff <= dir_ff;
      end
   end

   assign o_div = div_out_ff;
   assign o_ref = ref_out_ff;
   assign o_ind = ind_ff;
   assign o_enc_loss = loss_out_ff;
   assign o_enc_dir = dir_out_ff;
endmodule
`default_nettype wire

// ### logic/iec_params.svh
/*
 holds the constants of the incremental encoder card logic: timing counts,
 reset values and limits. assumes a 100 MHz core clock.
*/
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH
`define IEC_CLK_HZ 100000000
`define IEC_BLINK_HALF_MS 500
`define IEC_BLINK_HALF_CYC ((`IEC_CLK_HZ / 1000) * `IEC_BLINK_HALF_MS)
`define IEC_MAX_PULSE_KHZ 200
`define IEC_MIN_EDGE_CYC (`IEC_CLK_HZ / (`IEC_MAX_PULSE_KHZ * 1000 * 4))
`define IEC_FILT_LEN 3
`define IEC_LOSS_MS 100
`define IEC_LOSS_CYC ((`IEC_CLK_HZ / 1000) * `IEC_LOSS_MS)
`define IEC_RATIO_MIN 8'h01
`define IEC_RATIO_RST 8'h01
`endif

// ### logic/iec_pkg.sv
/*
 types of the incremental encoder card logic. assumes iec_params.svh
 carries the numbers.
*/
package iec_pkg;
   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } iec_abz_type;

   typedef enum logic [1:0] {
      IEC_LK_OFF = 2'b00,
      IEC_LK_SETUP = 2'b01,
      IEC_LK_UP = 2'b11
   } iec_link_type;

   typedef struct packed {
      logic link;
      logic enc;
      logic pwr;
   } iec_ind_type;
endpackage

// ### tb/iec_chk.sv
/* port assertions of iec_card, bound to each instance.
   assumes the short sim counts are handed on through the bind. */
`timescale 1ns/1ns
`default_nettype none
module iec_chk
   import iec_pkg::*;
#(
   parameter int BLINK_HALF_CYC = 10,
   parameter int LOSS_CYC = 50
) (
   // clock, reset and inputs
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire iec_abz_type i_enc,
   input wire iec_abz_type i_ref,
   input wire logic i_link_setup,
   input wire logic i_link_up,
   input wire logic i_power_fed,
   input wire logic i_motion_expected,
   // outputs
   input wire iec_abz_type o_div,
   input wire iec_abz_type o_ref,
   input wire logic o_enc_loss,
   input wire iec_ind_type o_ind
);
   logic [31:0] run_ff, up_ff, quiet_ff;
   logic last_ff;
   wire logic up_now = i_link_up && !i_link_setup;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // quiet counts from the pin edge, so it leads the filtered count inside
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         run_ff <= 32'h0;
         up_ff <= 32'h0;
         quiet_ff <= 32'h0;
         last_ff <= 1'b0;
      end else begin
         run_ff <= (o_ind.link != last_ff) ? 32'h1 : run_ff + 32'h1;
         up_ff <= up_now ? up_ff + 32'h1 : 32'h0;
         quiet_ff <= (i_motion_expected && $stable(i_enc[2:1])) ? quiet_ff + 32'h1 : 32'h0;
         last_ff <= o_ind.link;
      end
   end
   pwr_follow_a: assert property ($stable(i_power_fed)[*6] |-> o_ind.pwr == i_power_fed)
      else $error("power led lags");
   link_setup_a: assert property (i_link_setup[*8] |-> o_ind.link)
      else $error("link led dark in setup");
   link_off_a: assert property ((!i_link_setup && !i_link_up)[*8] |-> !o_ind.link)
      else $error("link led lit when lost");
   blink_half_a: assert property (
      up_ff > 2 * BLINK_HALF_CYC + 8 && o_ind.link != last_ff |-> run_ff == BLINK_HALF_CYC)
      else $error("blink phase length");
   loss_early_a: assert property ($rose(o_enc_loss) |-> quiet_ff >= LOSS_CYC)
      else $error("loss too early");
   loss_late_a: assert property (quiet_ff == LOSS_CYC + 20 |-> o_enc_loss)
      else $error("loss missed");
   enc_dark_a: assert property (o_enc_loss[*4] |-> !o_ind.enc)
      else $error("encoder led lit on loss");
   enc_lit_a: assert property ((!o_enc_loss)[*8] |-> o_ind.enc)
      else $error("encoder led dark");
   index_pass_a: assert property ($rose(i_enc.z) ##6 i_enc.z |-> ##[1:8] o_div.z)
      else $error("index not passed");
   quad_step_a: assert property (!($changed(o_div.a) && $changed(o_div.b)))
      else $error("a and b moved together");
   ref_follow_a: assert property ($stable(i_ref)[*8] |-> o_ref == i_ref)
      else $error("reference not followed");
   cover property ($rose(o_enc_loss));
   cover property ($rose(o_div.z));
   cover property (up_ff > 30 && o_ind.link != last_ff);
endmodule
bind iec_card iec_chk #(.BLINK_HALF_CYC(BLINK_HALF_CYC), .LOSS_CYC(LOSS_CYC)) iec_chk_i (
   .i_clk(i_clk), .i_rst_b(i_rst_b), .i_enc(i_enc), .i_ref(i_ref),
   .i_link_setup(i_link_setup), .i_link_up(i_link_up), .i_power_fed(i_power_fed),
   .i_motion_expected(i_motion_expected), .o_div(o_div), .o_ref(o_ref),
   .o_enc_loss(o_enc_loss), .o_ind(o_ind));
`default_nettype wire

// ### tb/iec_enc_src.sv
/* quadrature pin source standing in for an encoder or pulse reference.
   assumes the bench clock; a/b edges never closer than GAP cycles. */
`timescale 1ns/1ns
`default_nettype none
module iec_enc_src
   import iec_pkg::*;
#(
   parameter int GAP = 125
) (
   input wire logic i_clk,
   output var iec_abz_type o_pins
);
   logic [1:0] ph = 2'b00;
   initial o_pins = '0;
   // 125 cycles per edge is the 200 kHz limit, no faster
   task automatic step(input bit fwd);
      repeat (GAP) @(posedge i_clk);
      ph = fwd ? ph + 2'd1 : ph - 2'd1;
      o_pins.a <= ph[1] ^ ph[0];
      o_pins.b <= ph[1];
   endtask
   task automatic index;
      repeat (GAP) @(posedge i_clk);
      o_pins.z <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_pins.z <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/* bench of iec_card with two pin sources: link, power, divider, index,
   loss and reference paths. assumes iec_chk is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_top import iec_pkg::*;;
   localparam int BH = 10;
   localparam int LC = 600;
   logic i_clk, i_rst_b, lk_setup, lk_up, fault, pwr, motion, sel;
   logic [7:0] r1, r2;
   logic [1:0] lastq;
   iec_abz_type enc, refp, o_div, o_ref;
   iec_ind_type o_ind;
   logic o_enc_dir, o_enc_loss;
   int failures, checks_done, net, hi, lo;
   bit zseen;
   iec_enc_src enc_src_i (.i_clk(i_clk), .o_pins(enc));
   iec_enc_src ref_src_i (.i_clk(i_clk), .o_pins(refp));
   iec_card #(.BLINK_HALF_CYC(BH), .LOSS_CYC(LC)) iec_card_i (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_enc(enc), .i_ref(refp), .i_link_setup(lk_setup),
      .i_link_up(lk_up), .i_comm_fault(fault), .i_power_fed(pwr), .i_motion_expected(motion),
      .i_ratio_sel(sel), .i_division_ratio_param_first(r1), .i_division_ratio_param_second(r2),
      .o_div(o_div), .o_ref(o_ref), .o_enc_dir(o_enc_dir), .o_enc_loss(o_enc_loss), .o_ind(o_ind));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   function automatic logic [1:0] ph(input logic [1:0] q);
      return {q[0], q[1] ^ q[0]};
   endfunction
   // net phase steps of the divided pair, +1 forward
   always @(posedge i_clk) begin
      if (o_div.z === 1'b1)
         zseen = 1'b1;
      if (i_rst_b && {o_div.a, o_div.b} !== lastq)
         net += (ph({o_div.a, o_div.b}) - ph(lastq) == 2'd1) ? 1 : -1;
      lastq = {o_div.a, o_div.b};
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // length of the current link led phase, bounded
   task automatic span(input logic v, output int n);
      for (n = 0; n < 4 * BH && o_ind.link === v; n++)
         @(negedge i_clk);
   endtask
   task automatic t_link;
      #1 chk(o_ind.link, 1'b0);
      cyc(1);
      lk_setup <= 1'b1;
      cyc(12);
      #1 chk(o_ind.link, 1'b1);
      cyc(1);
      lk_setup <= 1'b0;
      lk_up <= 1'b1;
      span(1'b1, hi);
      span(1'b0, lo);
      span(1'b1, hi);
      chk(lo, BH);
      chk(hi, BH);
      cyc(1);
      lk_up <= 1'b0;
      cyc(12);
      #1 chk(o_ind.link, 1'b0);
   endtask
   task automatic t_div(input logic [7:0] rf, rs, input logic s, input int n, input bit fwd);
      int r;
      r = s ? rs : rf;
      cyc(1);
      r1 <= rf;
      r2 <= rs;
      sel <= s;
      zseen = 1'b0;
      net = 0;
      enc_src_i.index();
      cyc(20);
      chk(zseen, 1'b1);
      repeat (n) enc_src_i.step(fwd);
      cyc(20);
      chk(net, fwd ? n / r : -(n / r));
      chk(o_enc_dir, fwd);
   endtask
   initial begin
      repeat (60000) @(posedge i_clk);
      failures++;
      summarize();
   end
   initial begin
      {i_rst_b, lk_setup, lk_up, fault, pwr, sel} = '0;
      motion = 1'b1;
      r1 = 8'h01;
      r2 = 8'h01;
      cyc(16);
      i_rst_b <= 1'b1;
      cyc(8);
      #1 chk(o_ind.pwr, 1'b0);
      cyc(1);
      pwr <= 1'b1;
      cyc(8);
      #1 chk(o_ind.pwr, 1'b1);
      t_link();
      repeat (4) begin
         ref_src_i.step(1'b1);
         cyc(10);
         #1 chk(o_ref, refp);
      end
      t_div(8'h01, 8'h07, 1'b0, 8, 1'b1);
      t_div(8'h05, 8'h03, 1'b1, 12, 1'b1);
      t_div(8'hff, 8'h03, 1'b0, 255, 1'b1);
      t_div(8'h02, 8'h03, 1'b0, 8, 1'b0);
      cyc(1);
      fault <= 1'b1;
      cyc(LC + 40);
      #1 chk(o_enc_loss, 1'b1);
      chk(o_ind.enc, 1'b0);
      enc_src_i.step(1'b1);
      cyc(20);
      #1 chk(o_enc_loss, 1'b0);
      chk(o_ind.enc, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
